// File: hdl/bus_interface_mode_control.v
// mode control register of the system-bus interface, with lockout and bus-write cache policy
`timescale 1ns/1ps
`include "mode_ctrl_regs.vh"
module bus_interface_mode_control #(
	parameter REVISION = 1'b1 // arbitrary default; set per silicon pass
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// register port
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [11:0] reg_addr,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata_q,
	// processor lock events
	input  wire        interlocked_load,
	input  wire        conditional_store,
	// incoming bus write probe
	input  wire        bus_write,
	input  wire        bus_write_hits_lock,
	input  wire        bus_write_is_cond_store,
	input  wire        map_says_update,
	// lock and lockout outputs
	output reg         lock_valid_q,
	output reg         bus_lockout_q,
	output reg         write_blocked_q,
	output reg         cond_store_ok_q,
	// cache action and configuration
	output reg         bcache_invalidate_q,
	output reg         bcache_update_q,
	output reg  [1:0]  backup_cache_size_q,
	output reg  [1:0]  primary_cache_org_q
);

	// internal copies of the writable fields
	reg  [1:0] cond_store_fail_threshold_q;
	reg  [1:0] lock_policy_q;
	reg  [1:0] bus_write_cache_action_q;
	// failure count of the current contention episode
	reg  [5:0] fail_cnt_q;
	// decoded strobes and events
	wire       sel_wr;
	wire       sel_rd;
	wire       force_lock_clear;
	wire       pol_off_wr;
	wire [5:0] fail_limit;
	wire       fail_evt;
	wire       store_ok_evt;

	// address decode, shared by the write and read paths
	function addr_hit;
		input [11:0] addr;
		begin
			addr_hit = (addr == `MODE_CTRL_OFFSET);
		end
	endfunction

	// threshold decode from the two-bit failure code
	function [5:0] fail_threshold;
		input [1:0] code;
		begin
			case (code)
				2'h0:    fail_threshold = `FAIL_CNT_1;
				2'h1:    fail_threshold = `FAIL_CNT_8;
				2'h2:    fail_threshold = `FAIL_CNT_16;
				default: fail_threshold = `FAIL_CNT_32;
			endcase
		end
	endfunction

	// only one address decodes; strobes elsewhere are ignored
	assign sel_wr           = reg_wr && addr_hit(reg_addr);
	assign sel_rd           = reg_rd && addr_hit(reg_addr);
	assign force_lock_clear = sel_wr && reg_wdata[`MODE_CLR_BIT];
	// writing policy off drops lockout on the edge the field changes,
	// so no stale lockout survives one cycle into the off state
	assign pol_off_wr       = sel_wr && (reg_wdata[`MODE_POL_HI:`MODE_POL_LO] == `POL_OFF);
	assign fail_limit       = fail_threshold(cond_store_fail_threshold_q);
	// a conditional store fails when no valid lock is held
	assign fail_evt         = conditional_store && !lock_valid_q;
	assign store_ok_evt     = conditional_store && lock_valid_q;

	// writable fields; reserved bits are not stored
	// a write carrying the clear bit still loads the other fields
	// field outputs follow the write on the same edge
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			cond_store_fail_threshold_q <= `MODE_FIELD_RESET;
			lock_policy_q               <= `MODE_FIELD_RESET;
			primary_cache_org_q         <= `MODE_FIELD_RESET;
			bus_write_cache_action_q    <= `MODE_FIELD_RESET;
			backup_cache_size_q         <= `MODE_FIELD_RESET;
		end else if (sel_wr) begin
			cond_store_fail_threshold_q <= reg_wdata[`MODE_THR_HI:`MODE_THR_LO];
			lock_policy_q               <= reg_wdata[`MODE_POL_HI:`MODE_POL_LO];
			primary_cache_org_q         <= reg_wdata[`MODE_PORG_HI:`MODE_PORG_LO];
			bus_write_cache_action_q    <= reg_wdata[`MODE_WACT_HI:`MODE_WACT_LO];
			backup_cache_size_q         <= reg_wdata[`MODE_BSZ_HI:`MODE_BSZ_LO];
		end
	end

	// readback: clear bit is write-only, reserved read zero
	// read data stands one cycle, then returns to zero so a stray sample sees nothing
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata_q <= 32'h0000_0000;
		end else if (sel_rd) begin
			reg_rdata_q                              <= 32'h0000_0000;
			reg_rdata_q[`MODE_REV_BIT]               <= REVISION;
			reg_rdata_q[`MODE_THR_HI:`MODE_THR_LO]   <= cond_store_fail_threshold_q;
			reg_rdata_q[`MODE_POL_HI:`MODE_POL_LO]   <= lock_policy_q;
			reg_rdata_q[`MODE_PORG_HI:`MODE_PORG_LO] <= primary_cache_org_q;
			reg_rdata_q[`MODE_WACT_HI:`MODE_WACT_LO] <= bus_write_cache_action_q;
			reg_rdata_q[`MODE_BSZ_HI:`MODE_BSZ_LO]   <= backup_cache_size_q;
		end else begin
			reg_rdata_q <= 32'h0000_0000;
		end
	end

	// lock-valid flag; a hitting bus write wins over a new load in the same cycle
	// clear beats all so software can always break a stuck lock
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			lock_valid_q <= 1'b0;
		end else if (force_lock_clear) begin
			lock_valid_q <= 1'b0;
		end else if (bus_write && bus_write_hits_lock) begin
			lock_valid_q <= 1'b0;
		end else if (interlocked_load) begin
			lock_valid_q <= 1'b1;
		end else if (conditional_store) begin
			lock_valid_q <= 1'b0; // store consumes the lock
		end
	end

	// store outcome, registered for the processor side
	// a pulse one cycle after the store it answers
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			cond_store_ok_q <= 1'b0;
		end else begin
			cond_store_ok_q <= store_ok_evt;
		end
	end

	// failure counter and lockout; counts saturate at the threshold
	// saturating keeps the count in range for any later threshold code
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			fail_cnt_q    <= 6'h00;
			bus_lockout_q <= 1'b0;
		end else if (force_lock_clear || pol_off_wr || lock_policy_q == `POL_OFF) begin
			fail_cnt_q    <= 6'h00;
			bus_lockout_q <= 1'b0;
		end else if (store_ok_evt) begin
			fail_cnt_q    <= 6'h00; // success ends the contention episode
			bus_lockout_q <= 1'b0;
		end else if (fail_evt && !bus_lockout_q) begin
			if (fail_cnt_q + 6'h01 >= fail_limit) begin
				fail_cnt_q    <= fail_limit;
				bus_lockout_q <= 1'b1;
			end else begin
				fail_cnt_q <= fail_cnt_q + 6'h01;
			end
		end
	end

	// bus write blocking while lockout is asserted
	// policy 11 is undefined and blocks no writes, as off does, though failures still count and raise lockout
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			write_blocked_q <= 1'b0;
		end else begin
			case (lock_policy_q)
				`POL_ALL_WRITES: write_blocked_q <= bus_write && bus_lockout_q;
				`POL_COND_ONLY:  write_blocked_q <= bus_write && bus_lockout_q && bus_write_is_cond_store;
				default:         write_blocked_q <= 1'b0;
			endcase
		end
	end

	// backup-cache action for incoming writes
	// write mode 11 is undefined; doing nothing is the safe choice
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			bcache_invalidate_q <= 1'b0;
			bcache_update_q     <= 1'b0;
		end else begin
			bcache_invalidate_q <= 1'b0;
			bcache_update_q     <= 1'b0;
			if (bus_write) begin
				case (bus_write_cache_action_q)
					`WACT_MAP: begin
						bcache_update_q     <= map_says_update;
						bcache_invalidate_q <= !map_says_update;
					end
					`WACT_INVAL:  bcache_invalidate_q <= 1'b1;
					`WACT_UPDATE: bcache_update_q     <= 1'b1;
					default: begin
						bcache_invalidate_q <= 1'b0; // undefined code: no action
					end
				endcase
			end
		end
	end

endmodule

// File: hdl/mode_ctrl_regs.vh
// register offsets, field positions, reset values and counts for the mode control register
`ifndef MODE_CTRL_REGS_VH
`define MODE_CTRL_REGS_VH
`define MODE_CTRL_OFFSET      12'h0C00
`define MODE_REV_BIT          16
`define MODE_CLR_BIT          10
`define MODE_THR_HI           9
`define MODE_THR_LO           8
`define MODE_POL_HI           7
`define MODE_POL_LO           6
`define MODE_PORG_HI          5
`define MODE_PORG_LO          4
`define MODE_WACT_HI          3
`define MODE_WACT_LO          2
`define MODE_BSZ_HI           1
`define MODE_BSZ_LO           0
`define MODE_FIELD_RESET      2'h0
`define FAIL_CNT_1            6'h01
`define FAIL_CNT_8            6'h08
`define FAIL_CNT_16           6'h10
`define FAIL_CNT_32           6'h20
`define POL_OFF               2'h0
`define POL_ALL_WRITES        2'h1
`define POL_COND_ONLY         2'h2
`define WACT_MAP              2'h0
`define WACT_INVAL            2'h1
`define WACT_UPDATE           2'h2
`endif

// File: bench/mode_ctrl_checker.sv
// port-level checks on the mode control register
`timescale 1ns/1ps
module mode_ctrl_checker #(parameter REVISION = 1'b1) (
	// clock, reset, register port
	input logic        clk_sys,
	input logic        rst_n,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [11:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic [31:0] reg_rdata_q,
	// bus side
	input logic        bus_write,
	input logic        bus_lockout_q,
	input logic        write_blocked_q,
	input logic        bcache_invalidate_q,
	input logic        bcache_update_q,
	input logic [1:0]  backup_cache_size_q
);
	// only one address decodes, so strobes elsewhere must do nothing
	wire wr_hit = reg_wr && reg_addr == 12'h0C00;
	wire rd_hit = reg_rd && reg_addr == 12'h0C00;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_rsvd_reads_zero: assert property (reg_rdata_q[31:17] == 0 && reg_rdata_q[15:10] == 0)
		else $error("reserved bits set");
	chk_reset_clears: assert property (!$past(rst_n) |-> !bus_lockout_q && backup_cache_size_q == 0)
		else $error("not cleared");
	chk_rev_bit: assert property ($past(rd_hit) |-> reg_rdata_q[16] == REVISION)
		else $error("bad revision");
	chk_size_field: assert property ($past(wr_hit) |-> backup_cache_size_q == $past(reg_wdata[1:0]))
		else $error("size stale");
	chk_clear_lock: assert property (wr_hit && reg_wdata[10] |=> !bus_lockout_q)
		else $error("lockout kept");
	chk_policy_off: assert property (wr_hit && reg_wdata[7:6] == 0 |=> !bus_lockout_q [*3])
		else $error("lockout while off");
	chk_block_cause: assert property (write_blocked_q |-> $past(bus_write && bus_lockout_q))
		else $error("block without lockout");
	chk_one_action: assert property (bcache_invalidate_q |-> !bcache_update_q && $past(bus_write))
		else $error("bad cache action");
endmodule
bind bus_interface_mode_control mode_ctrl_checker #(.REVISION(REVISION)) i_chk (.*);

// File: bench/bus_node_model.sv
// another node on the shared bus, issuing single-cycle writes
`timescale 1ns/1ps
module bus_node_model (
	// clock
	input  logic clk_sys,
	// write and qualifiers
	output logic bus_write,
	output logic bus_write_hits_lock,
	output logic bus_write_is_cond_store,
	output logic map_says_update
);
	// idle bus carries no write
	initial {bus_write, bus_write_hits_lock, bus_write_is_cond_store, map_says_update} = 4'h0;
	// qualifiers live only with the write cycle
	task automatic send(input logic hit, input logic cs, input logic upd);
		@(posedge clk_sys);
		{bus_write, bus_write_hits_lock, bus_write_is_cond_store, map_says_update} <= {1'b1, hit, cs, upd};
		@(posedge clk_sys);
		{bus_write, bus_write_hits_lock, bus_write_is_cond_store, map_says_update} <= 4'h0;
	endtask
endmodule

// File: bench/bus_interface_mode_control_tb.sv
// self-checking bench for the mode control register
`timescale 1ns/1ps
module bus_interface_mode_control_tb;
	logic        clk_sys, rst_n, reg_wr, reg_rd, interlocked_load, conditional_store;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata_q;
	logic        bus_write, bus_write_hits_lock, bus_write_is_cond_store, map_says_update;
	logic        lock_valid_q, bus_lockout_q, write_blocked_q, cond_store_ok_q;
	logic        bcache_invalidate_q, bcache_update_q;
	logic [1:0]  backup_cache_size_q, primary_cache_org_q;
	int          fails = 0, cmp_count = 0, w, u;
	bus_interface_mode_control i_dut (.*);
	bus_node_model i_node (.*);
	// 40 MHz
	initial begin
		clk_sys = 0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [31:0] d);
		@(posedge clk_sys);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, 12'h0C00, d};
		@(posedge clk_sys);
		reg_wr <= 0;
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 chk(reg_rdata_q, e);
	endtask
	// n one-cycle pulses on one processor event
	task automatic ev(input int n, input bit load);
		repeat (n) begin
			@(posedge clk_sys);
			{interlocked_load, conditional_store} <= {load, !load};
			@(posedge clk_sys);
			{interlocked_load, conditional_store} <= 2'h0;
		end
		#1;
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{rst_n, reg_wr, reg_rd, interlocked_load, conditional_store, reg_addr, reg_wdata} = 0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1;
		rd(12'h0C00, 32'h0001_0000);
		rd(12'h0C40, 0);
		for (w = 0; w < 3; w++)
			for (u = 0; u < 2; u++) begin
				wr(32'h0000_0020 | w << 2 | w);
				chk(backup_cache_size_q, w);
				chk(primary_cache_org_q, 2);
				i_node.send(0, 0, u[0]);
				#1 chk({bcache_invalidate_q, bcache_update_q}, w ? {w == 1, w == 2} : {!u[0], u[0]});
			end
		rd(12'h0C00, 32'h0001_002A);
		// every threshold code: clear, then count failures up to it
		for (w = 0; w < 4; w++) begin
			wr(32'h0000_0460 | w << 8);
			ev(w ? (4 << w) - 1 : 0, 0);
			chk(bus_lockout_q, 0);
			ev(1, 0);
			chk(bus_lockout_q, 1);
		end
		i_node.send(0, 0, 0);
		#1 chk(write_blocked_q, 1);
		wr(32'h0000_0420);
		chk(bus_lockout_q, 0);
		rd(12'h0C00, 32'h0001_0020);
		wr(32'h0000_04A0);
		ev(1, 0);
		i_node.send(0, 0, 0);
		#1 chk({bus_lockout_q, write_blocked_q}, 2'h2);
		i_node.send(0, 1, 0);
		#1 chk(write_blocked_q, 1);
		// policy off without the clear bit must drop lockout as well
		wr(32'h0000_0020);
		chk(bus_lockout_q, 0);
		wr(32'h0000_0420);
		ev(1, 0);
		chk(bus_lockout_q, 0);
		ev(1, 1);
		i_node.send(1, 0, 0);
		#1 chk(lock_valid_q, 0);
		ev(1, 1);
		ev(1, 0);
		chk({lock_valid_q, cond_store_ok_q}, 2'h1);
		test_done;
	end
	// whole run needs well under 1000 cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		test_done;
	end
endmodule
